// ---- logic/eirp_map.vh ----
// constants for the external interrupt and reset pin block
`ifndef EIRP_MAP_VH
`define EIRP_MAP_VH

// vector table layout
`define EIRP_VEC_PAGE_W 16
`define EIRP_VEC_ADDR_W 24
`define EIRP_RESET_PAGE 16'hffff
`define EIRP_VEC_STRIDE_SH 3

// source codes, also the vector index
`define EIRP_SRC_W 3
`define EIRP_SRC_RESET 3'h0
`define EIRP_SRC_NMI 3'h1
`define EIRP_SRC_INT0 3'h2
`define EIRP_SRC_INT1 3'h3
`define EIRP_SRC_INT2 3'h4
`define EIRP_SRC_INT3 3'h5

// timer signal select values
`define EIRP_TSS_NMI 1'b0
`define EIRP_TSS_WDT 1'b1

// vector fetch length in clock cycles
`define EIRP_ACK_CYCLES 2

// reset values
`define EIRP_PIN_IDLE 1'b1
`define EIRP_ACK_N_RST 1'b1

`endif

// ---- logic/eirp_sync.v ----
// two flip-flop synchroniser for asynchronous pin levels
module eirp_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
   input wire clk_sys_in,          // system clock
   input wire rst_in,              // async reset, active high
   input wire [W-1:0] async_in,    // raw pin levels
   output wire [W-1:0] sync_out    // synchronised levels
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // meta_r feeds only sync_r
   always @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end
      else
      begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;
endmodule

// ---- logic/eirp_top.v ----
// external interrupt, non-maskable interrupt/watchdog pin and reset sequencing
// Summary of operation
// R1 - four maskable external interrupts are each enabled by a bit in one of two enable registers.
// R2 - a global mask bit in status register one blocks all maskable interrupts together.
// R3 - each maskable interrupt latches a pending flag that software can read and clear.
// R4 - pending interrupts are taken in a fixed order: reset, nmi, int0, int1, int2, int3.
// R5 - the non-maskable interrupt ignores every enable and mask and is always taken; here it waits for cpu_int_ready_in and is not latched in watchdog mode.
// R6 - the shared pin is the nmi input or the watchdog pin per timer signal select, nmi by default.
// R7 - in watchdog mode the watchdog timer both drives and senses the shared pin.
// R8 - the acknowledge output goes low while an accepted interrupt's vector is fetched.
// R9 - the acknowledge output is high while reset is active.
// R10 - reset halts program execution and returns control state to its reset values.
// R11 - after reset the reset vector is fetched at page ffff offset 00, address ffff00.
// R12 - external sources drive interrupt and reset lines active low and hold them long enough; rst_in here is active high.
`include "eirp_map.vh"

module eirp_top #(
   parameter ACK_CYCLES = `EIRP_ACK_CYCLES,
   parameter CNT_W = 4
) (
   input wire clk_sys_in,                       // system clock, 20 MHz
   input wire rst_in,                           // async reset, active high
   input wire [3:0] ext_int_n_in,               // maskable interrupt pins, active low
   input wire nmi_wdt_pin_in,                   // shared pin level as seen on the pad
   output reg nmi_wdt_pin_out,                  // shared pin drive value
   output reg nmi_wdt_pin_oe_out,               // shared pin drive enable, high drives
   input wire timer_signal_select_in,           // 0 nmi function, 1 watchdog function
   input wire watchdog_drive_in,                // watchdog timer output value
   input wire watchdog_oe_in,                   // watchdog timer wants to drive the pin
   output wire watchdog_pin_out,                // synchronised pin level for the watchdog
   input wire [1:0] irq_enable_reg0_in,         // enables for int0 and int1
   input wire [1:0] irq_enable_reg1_in,         // enables for int2 and int3
   input wire global_irq_mask_in,               // status register one mask, 1 blocks
   input wire [1:0] irq_flag_clr0_in,           // clear pulses for int0 and int1 flags
   input wire [1:0] irq_flag_clr1_in,           // clear pulses for int2 and int3 flags
   output wire [1:0] irq_flag_reg0_out,         // pending flags of int0 and int1
   output wire [1:0] irq_flag_reg1_out,         // pending flags of int2 and int3
   output reg nmi_pending_out,                  // nmi waiting to be taken
   input wire [15:0] vector_pointer_data_in,    // vector page for interrupts
   input wire cpu_int_ready_in,                 // core can take an interrupt this cycle
   output reg irq_ack_n_out,                    // interrupt acknowledge, active low
   output reg vec_fetch_out,                    // vector fetch in progress
   output reg [23:0] vec_addr_out,              // vector address on the program bus
   output reg [2:0] vec_src_out,                // source being served
   output reg cpu_run_out                       // core may execute
);
   localparam ST_RST_FETCH = 2'b00;
   localparam ST_IDLE = 2'b01;
   localparam ST_ACK = 2'b10;

   wire [3:0] int_sync;
   wire nmi_sync;
   reg [3:0] int_prev_r;
   reg nmi_prev_r;
   reg [3:0] flag_r;
   reg [3:0] flag_nxt;
   reg nmi_nxt;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [CNT_W-1:0] cnt_r;
   reg [CNT_W-1:0] cnt_nxt;
   reg [3:0] take_clr;
   reg take_nmi;
   reg [2:0] src_sel;
   reg req_any;
   reg ack_n_nxt;
   reg fetch_nxt;
   reg [23:0] addr_nxt;
   reg [2:0] src_nxt;
   reg run_nxt;
   wire [3:0] enables;
   wire [3:0] int_fall;
   wire nmi_fall;
   wire [3:0] maskable_req;

   // vector address of a source on a given page
   function [23:0] eirp_vec_addr;
      input [15:0] page;
      input [2:0] src;
      begin
         eirp_vec_addr = {page, 8'h00} | ({21'h000000, src} << `EIRP_VEC_STRIDE_SH);
      end
   endfunction

   eirp_sync #(
      .W(4),
      .RST_VAL(4'hf)
   ) u_int_sync (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .async_in(ext_int_n_in),
      .sync_out(int_sync)
   );

   eirp_sync #(
      .W(1),
      .RST_VAL(`EIRP_PIN_IDLE)
   ) u_nmi_sync (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .async_in(nmi_wdt_pin_in),
      .sync_out(nmi_sync)
   );

   // shared pin: watchdog mode hands drive and sense to the timer
   always @*
   begin
      nmi_wdt_pin_out = watchdog_drive_in;
      nmi_wdt_pin_oe_out = (timer_signal_select_in == `EIRP_TSS_WDT) && watchdog_oe_in; // R6 R7
   end
   // idle level when the pin belongs to nmi, so the timer sees no stray edges
   assign watchdog_pin_out = (timer_signal_select_in == `EIRP_TSS_WDT) ?
                             nmi_sync : `EIRP_PIN_IDLE; // R7

   assign enables = {irq_enable_reg1_in, irq_enable_reg0_in}; // R1
   assign int_fall = int_prev_r & ~int_sync;
   // a low nmi input is ignored while the pin serves the watchdog
   assign nmi_fall = nmi_prev_r & ~nmi_sync &
                     (timer_signal_select_in == `EIRP_TSS_NMI); // R6
   assign maskable_req = flag_r & enables & {4{~global_irq_mask_in}}; // R1 R2
   assign irq_flag_reg0_out = flag_r[1:0];
   assign irq_flag_reg1_out = flag_r[3:2];

   // fixed priority pick; nmi sits above all maskable sources
   always @*
   begin
      take_clr = 4'h0;
      take_nmi = 1'b0;
      src_sel = `EIRP_SRC_NMI;
      req_any = 1'b1;
      if (nmi_pending_out) // R4 R5
      begin
         take_nmi = 1'b1;
         src_sel = `EIRP_SRC_NMI;
      end
      else if (maskable_req[0]) // R4
      begin
         take_clr = 4'h1;
         src_sel = `EIRP_SRC_INT0;
      end
      else if (maskable_req[1])
      begin
         take_clr = 4'h2;
         src_sel = `EIRP_SRC_INT1;
      end
      else if (maskable_req[2])
      begin
         take_clr = 4'h4;
         src_sel = `EIRP_SRC_INT2;
      end
      else if (maskable_req[3])
      begin
         take_clr = 4'h8;
         src_sel = `EIRP_SRC_INT3;
      end
      else
      begin
         req_any = 1'b0;
      end
   end

   always @*
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      ack_n_nxt = irq_ack_n_out;
      fetch_nxt = vec_fetch_out;
      addr_nxt = vec_addr_out;
      src_nxt = vec_src_out;
      run_nxt = cpu_run_out;
      flag_nxt = flag_r;
      nmi_nxt = nmi_pending_out;
      case (state_r)
         ST_RST_FETCH:
         begin
            // first cycle after release: core still halted, reset vector on the bus
            ack_n_nxt = 1'b0;
            fetch_nxt = 1'b1;
            addr_nxt = eirp_vec_addr(`EIRP_RESET_PAGE, `EIRP_SRC_RESET); // R11
            src_nxt = `EIRP_SRC_RESET;
            cnt_nxt = ACK_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
            state_nxt = ST_ACK;
         end
         ST_IDLE:
         begin
            if (cpu_int_ready_in && req_any)
            begin
               ack_n_nxt = 1'b0; // R8
               fetch_nxt = 1'b1;
               addr_nxt = eirp_vec_addr(vector_pointer_data_in, src_sel);
               src_nxt = src_sel;
               cnt_nxt = ACK_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
               flag_nxt = flag_r & ~take_clr;
               if (take_nmi)
               begin
                  nmi_nxt = 1'b0;
               end
               state_nxt = ST_ACK;
            end
         end
         ST_ACK:
         begin
            if (cnt_r == {CNT_W{1'b0}})
            begin
               ack_n_nxt = 1'b1;
               fetch_nxt = 1'b0;
               run_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
            else
            begin
               cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
      // software clear, then new edges: an edge in the clearing cycle still sets
      flag_nxt = (flag_nxt & ~{irq_flag_clr1_in, irq_flag_clr0_in}) | int_fall; // R3
      nmi_nxt = nmi_nxt | nmi_fall; // R5
   end

   always @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_r <= ST_RST_FETCH; // R10
         cnt_r <= {CNT_W{1'b0}};
         irq_ack_n_out <= `EIRP_ACK_N_RST; // R9
         vec_fetch_out <= 1'b0;
         vec_addr_out <= 24'h000000;
         vec_src_out <= `EIRP_SRC_RESET;
         cpu_run_out <= 1'b0; // R10
         flag_r <= 4'h0;
         nmi_pending_out <= 1'b0;
         int_prev_r <= 4'hf;
         nmi_prev_r <= `EIRP_PIN_IDLE;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         irq_ack_n_out <= ack_n_nxt;
         vec_fetch_out <= fetch_nxt;
         vec_addr_out <= addr_nxt;
         vec_src_out <= src_nxt;
         cpu_run_out <= run_nxt;
         flag_r <= flag_nxt;
         nmi_pending_out <= nmi_nxt;
         int_prev_r <= int_sync;
         nmi_prev_r <= nmi_sync;
      end
   end
endmodule

// ---- tb/eirp_chk_monitor.sv ----
// assertion checker for the interrupt and reset pin block
module eirp_chk (
   input wire logic clk_sys_in, // system clock
   input wire logic rst_in, // async reset, active high
   input wire logic irq_ack_n_out, // acknowledge, active low
   input wire logic vec_fetch_out, // vector fetch in progress
   input wire logic cpu_run_out, // core may execute
   input wire logic nmi_pending_out, // nmi waiting
   input wire logic global_irq_mask_in, // global mask, 1 blocks
   input wire logic cpu_int_ready_in, // core can take an interrupt
   input wire logic timer_signal_select_in, // shared pin function
   input wire logic watchdog_oe_in, // watchdog wants the pin
   input wire logic watchdog_drive_in, // watchdog drive value
   input wire logic nmi_wdt_pin_oe_out, // shared pin drive enable
   input wire logic nmi_wdt_pin_out, // shared pin drive value
   input wire logic watchdog_pin_out, // pin level for the watchdog
   input wire logic [23:0] vec_addr_out, // vector address
   input wire logic [2:0] vec_src_out, // source being served
   input wire logic [15:0] vector_pointer_data_in // vector page
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   sequence s_fetch;
      !irq_ack_n_out [*2] ##1 irq_ack_n_out;
   endsequence
   // an acceptance by the running core, not the reset vector fetch
   sequence s_take;
      $fell(irq_ack_n_out) && $past(cpu_run_out);
   endsequence
   chk_rst_ack: assert property (disable iff (1'b0)
      rst_in |-> irq_ack_n_out && !cpu_run_out) else $error("ack or run wrong in reset");
   // the fetch is loaded at the first edge after release and seen at the next
   chk_rst_vec: assert property ($past(rst_in) && !rst_in |=>
      !irq_ack_n_out && vec_addr_out == 24'hffff00 && vec_src_out == 3'h0)
      else $error("reset vector fetch wrong");
   chk_ack_len: assert property ($fell(irq_ack_n_out) |-> s_fetch)
      else $error("ack low length wrong");
   chk_fetch_tie: assert property (vec_fetch_out == !irq_ack_n_out)
      else $error("fetch and ack disagree");
   chk_vec_addr: assert property (s_take |->
      vec_addr_out == {$past(vector_pointer_data_in), 2'b00, vec_src_out, 3'b000})
      else $error("vector address wrong");
   chk_mask_gate: assert property (s_take ##0 vec_src_out > 3'h1 |->
      !$past(global_irq_mask_in) && $past(cpu_int_ready_in)) else $error("masked taken");
   chk_nmi_first: assert property (s_take ##0 $past(nmi_pending_out) |->
      vec_src_out == 3'h1) else $error("nmi not first");
   chk_run_gate: assert property ($rose(cpu_run_out) |->
      $past(vec_fetch_out) && irq_ack_n_out) else $error("run before vector fetch");
   chk_pin_mux: assert property (nmi_wdt_pin_out == watchdog_drive_in &&
      nmi_wdt_pin_oe_out == (timer_signal_select_in && watchdog_oe_in))
      else $error("shared pin drive wrong");
   chk_wdt_sense: assert property (!timer_signal_select_in |-> watchdog_pin_out)
      else $error("watchdog sense in nmi mode");
endmodule

bind eirp_top eirp_chk u_chk (
   .clk_sys_in(clk_sys_in),
   .rst_in(rst_in),
   .irq_ack_n_out(irq_ack_n_out),
   .vec_fetch_out(vec_fetch_out),
   .cpu_run_out(cpu_run_out),
   .nmi_pending_out(nmi_pending_out),
   .global_irq_mask_in(global_irq_mask_in),
   .cpu_int_ready_in(cpu_int_ready_in),
   .timer_signal_select_in(timer_signal_select_in),
   .watchdog_oe_in(watchdog_oe_in),
   .watchdog_drive_in(watchdog_drive_in),
   .nmi_wdt_pin_oe_out(nmi_wdt_pin_oe_out),
   .nmi_wdt_pin_out(nmi_wdt_pin_out),
   .watchdog_pin_out(watchdog_pin_out),
   .vec_addr_out(vec_addr_out),
   .vec_src_out(vec_src_out),
   .vector_pointer_data_in(vector_pointer_data_in)
);

// ---- tb/eirp_pins.sv ----
// model of the external sources on the interrupt pins and shared pad
module eirp_pins (
   input wire logic [4:0] lvl_in,    // wanted levels, bit 4 the nmi source
   input wire logic oe_in,           // block drives the pad
   input wire logic drv_in,          // block drive value
   output logic [3:0] int_n_out,     // maskable pins
   output logic pad_out              // resolved shared pad
);
   timeunit 1ns;
   timeprecision 1ns;
   assign int_n_out = lvl_in[3:0];
   // the block wins the pad while it drives; otherwise the pad follows the nmi source level
   assign pad_out = oe_in ? drv_in : lvl_in[4];
endmodule

// ---- tb/tb_top.sv ----
// testbench for the interrupt and reset pin block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b0;
   logic [4:0] lvl = 5'h1f;
   logic [3:0] int_n;
   logic pad, oe, drv, sel = 1'b0, wd_drv = 1'b0, wd_oe = 1'b0, mask = 1'b0, rdy = 1'b0;
   logic [1:0] en0 = 2'h0, en1 = 2'h0, clr0 = 2'h0, clr1 = 2'h0, fl0, fl1;
   logic ack_n, fetch, run, nmi_p, wd_pin;
   logic [23:0] addr;
   logic [2:0] src;
   int fails = 0;
   int comparisons = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   eirp_pins pins (.lvl_in(lvl), .oe_in(oe), .drv_in(drv), .int_n_out(int_n), .pad_out(pad));
   eirp_top #(.ACK_CYCLES(2)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .ext_int_n_in(int_n), .nmi_wdt_pin_in(pad), .nmi_wdt_pin_out(drv),
      .nmi_wdt_pin_oe_out(oe), .timer_signal_select_in(sel), .watchdog_drive_in(wd_drv),
      .watchdog_oe_in(wd_oe), .watchdog_pin_out(wd_pin), .irq_enable_reg0_in(en0),
      .irq_enable_reg1_in(en1), .global_irq_mask_in(mask), .irq_flag_clr0_in(clr0),
      .irq_flag_clr1_in(clr1), .irq_flag_reg0_out(fl0), .irq_flag_reg1_out(fl1),
      .nmi_pending_out(nmi_p), .vector_pointer_data_in(16'h1234), .cpu_int_ready_in(rdy),
      .irq_ack_n_out(ack_n), .vec_fetch_out(fetch), .vec_addr_out(addr),
      .vec_src_out(src), .cpu_run_out(run));
   task chk(input string nm, input logic [23:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // pulses stay low and high 4 cycles so the synchronisers see each level
   task pl(input logic [4:0] m);
      lvl = ~m;
      repeat (4) @(negedge clk_sys_in);
      lvl = 5'h1f;
      repeat (4) @(negedge clk_sys_in);
   endtask
   task take(input logic [2:0] s, input logic [23:0] a);
      int n;
      n = 0;
      rdy = 1'b1;
      while (ack_n !== 1'b0 && n < 20)
      begin
         @(posedge clk_sys_in);
         #1 n++;
      end
      chk("src", s, src);
      chk("addr", a, addr);
      chk("fetch", 1, fetch);
      repeat (3) @(negedge clk_sys_in);
      rdy = 1'b0;
      // let one edge pass so a following call never re-raises ready in the same step
      @(negedge clk_sys_in);
   endtask
   task close_out;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      fails++;
      close_out;
   end
   initial
   begin
      // a declaration initialiser makes no edge, so reset is raised once the flops listen
      #1 rst_in = 1'b1;
      repeat (8) @(negedge clk_sys_in);
      chk("ack_rst", 1, ack_n);
      chk("run_rst", 0, run);
      rst_in = 1'b0;
      @(posedge clk_sys_in);
      #1 chk("rst_vec", 24'hffff00, addr);
      chk("rst_ack", 0, ack_n);
      repeat (2) @(posedge clk_sys_in);
      #1 chk("run", 1, run);
      $display("reset test done");
      @(negedge clk_sys_in);
      en0 = 2'h3;
      en1 = 2'h2;
      mask = 1'b1;
      pl(5'h02);
      chk("flag0", 2'h2, fl0);
      rdy = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      chk("ack_masked", 1, ack_n);
      rdy = 1'b0;
      clr0 = 2'h2;
      @(negedge clk_sys_in);
      clr0 = 2'h0;
      chk("flag_clr", 2'h0, fl0);
      $display("mask test done");
      pl(5'h0d);
      mask = 1'b0;
      take(3'h2, 24'h123410);
      take(3'h5, 24'h123428);
      chk("flag1", 2'h1, fl1);
      $display("priority test done");
      mask = 1'b1;
      en0 = 2'h0;
      pl(5'h10);
      take(3'h1, 24'h123408);
      $display("nmi test done");
      sel = 1'b1;
      wd_oe = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      chk("pin_oe", 1, oe);
      chk("pin_drv", 0, drv);
      chk("wdt_sense", 0, wd_pin);
      wd_oe = 1'b0;
      pl(5'h10);
      chk("nmi_ignored", 0, nmi_p);
      $display("pin test done");
      close_out;
   end
endmodule
